// File: hdl/asc_device.sv
// Converter end: control-byte capture, strobe and result shift-out.
// Assumes sampleData holds the conversion value, on mclk, when the strobe rises.
//
// Function
// - Power bits 01 fast, 10 reduced, 11 normal
// - Low-power modes keep link clock at most 4.8MHz
// - Results use straight binary in every input mode
// - Host clock 4.0MHz, idle low, first-edge capture
// - Transmit and receive clocks active high, shared
// - Pull select low before shifting control data
// - Control word 1XXXXX11 starts normal-mode conversion
// - Strobe falling edge marks conversion and data
// - Host takes sixteen bits on following rising edges
// - Twelve result bits first, four trailing bits dropped
// - Select returns high after reading the result
// - First high bit while idle is start bit
// - Strobe high one clock, then twelve decisions
// - Low-power mode applies after conversion, until next byte
// - Power bits 00 mean full power-down
`timescale 1ns/1ps
module asc_device
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Serial link
    asc_link_if.dev                     link,
    // Converter side
    input  wire logic                   hwShutdownN,
    input  wire logic [RESULT_BITS-1:0] sampleData,
    output logic                        sampleTaken,
    output logic [CB_CFG_W-1:0]         channelConfig,
    output logic                        conversionBusy,
    // Power state
    output logic                        normalMode,
    output logic                        fastPowerdownMode,
    output logic                        reducedPowerMode,
    output logic                        fullPowerdownMode,
    output logic                        hwShutdown
);
    asc_dev_state_type      state_r;
    logic [3:0]             sy1_r, sy2_r, sy3_r, st_r, stNxt;
    logic                   rise, fall, csLow, dinV, shutN;
    logic [4:0]             bitCnt_r;
    logic [7:0]             ctrlSh_r;
    logic [RESULT_BITS-1:0] resSh_r;
    logic [1:0]             pendPd_r, activePd_r;
    logic                   dout_r, strobe_r, oe_r, taken_r, busy_r;
    logic [CB_CFG_W-1:0]    cfg_r;
    logic                   normal_r, fast_r, reduced_r, full_r, shut_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: {shutdown, select, clock, data}
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sy1_r <= DEV_SYNC_RESET;
            sy2_r <= DEV_SYNC_RESET;
            sy3_r <= DEV_SYNC_RESET;
            st_r  <= DEV_SYNC_RESET;
        end
        else
        begin
            sy1_r <= {hwShutdownN, link.csN, link.sclk, link.din};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            st_r  <= stNxt;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            stNxt[i] = ascFilt(sy2_r[i], sy3_r[i], st_r[i]);
    end

    assign rise  = stNxt[1] & ~st_r[1];
    assign fall  = ~stNxt[1] & st_r[1];
    assign dinV  = stNxt[0];
    assign csLow = ~stNxt[2];
    assign shutN = stNxt[3];

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_r <= D_IDLE;
        else if (!shutN)
            state_r <= D_IDLE;
        else
            unique case (state_r)
                D_IDLE: if (rise && csLow && dinV) state_r <= D_CTRL;
                D_CTRL: if (rise && csLow && bitCnt_r == CTRL_LAST_CNT)
                            state_r <= D_ARM;
                D_ARM:  if (fall) state_r <= D_STRB;
                D_STRB: if (fall) state_r <= D_DATA;
                D_DATA: if (fall && bitCnt_r == FRAME_LAST_CNT)
                            state_r <= D_IDLE;
            endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bitCnt_r <= 5'h00;
            ctrlSh_r <= CTRL_RESET;
        end
        else if (state_r == D_IDLE && rise && csLow && dinV)
        begin
            bitCnt_r <= 5'h01;
            ctrlSh_r <= 8'h01;
        end
        else if (state_r == D_CTRL && rise && csLow)
        begin
            bitCnt_r <= bitCnt_r + 5'h01;
            ctrlSh_r <= {ctrlSh_r[6:0], dinV};
        end
        else if (state_r == D_ARM && fall)
            bitCnt_r <= 5'h00;
        else if ((state_r == D_STRB || state_r == D_DATA) && fall)
            bitCnt_r <= bitCnt_r + 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe and result shift-out
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strobe_r <= 1'b0;
            dout_r   <= 1'b0;
            resSh_r  <= '0;
            cfg_r    <= '0;
            pendPd_r <= MODE_RESET;
            taken_r  <= 1'b0;
        end
        else
        begin
            taken_r <= 1'b0;
            if (!shutN)
            begin
                strobe_r <= 1'b0;
                dout_r   <= 1'b0;
            end
            else if (state_r == D_ARM && fall)
            begin
                strobe_r <= 1'b1;
                resSh_r  <= sampleData;
                cfg_r    <= ctrlSh_r[CB_CFG_LSB +: CB_CFG_W];
                pendPd_r <= ctrlSh_r[CB_PD_LSB +: 2];
                taken_r  <= 1'b1;
            end
            else if ((state_r == D_STRB || state_r == D_DATA) && fall)
            begin
                strobe_r <= 1'b0;
                // Zero fill supplies the four trailing bits
                dout_r   <= (bitCnt_r == FRAME_LAST_CNT) ? 1'b0 : resSh_r[11];
                resSh_r  <= {resSh_r[10:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            oe_r <= 1'b0;
        else
            oe_r <= csLow;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power mode: full power while converting, programmed mode afterwards
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            activePd_r <= MODE_RESET;
        else if (state_r == D_IDLE && rise && csLow && dinV)
            activePd_r <= PD_NORMAL;
        else if (state_r == D_DATA && fall && bitCnt_r == FRAME_LAST_CNT)
            activePd_r <= pendPd_r;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            normal_r  <= 1'b1;
            fast_r    <= 1'b0;
            reduced_r <= 1'b0;
            full_r    <= 1'b0;
            shut_r    <= 1'b0;
            busy_r    <= 1'b0;
        end
        else
        begin
            normal_r  <= shutN && activePd_r == PD_NORMAL;
            fast_r    <= shutN && activePd_r == PD_FAST;
            reduced_r <= shutN && activePd_r == PD_REDUCED;
            full_r    <= shutN && activePd_r == PD_FULL;
            shut_r    <= !shutN;
            busy_r    <= (state_r != D_IDLE);
        end
    end

    assign link.dout             = dout_r;
    assign link.doutOe           = oe_r;
    assign link.conversionStrobe = strobe_r;
    assign link.strobeOe         = oe_r;
    assign sampleTaken           = taken_r;
    assign channelConfig         = cfg_r;
    assign conversionBusy        = busy_r;
    assign normalMode            = normal_r;
    assign fastPowerdownMode     = fast_r;
    assign reducedPowerMode      = reduced_r;
    assign fullPowerdownMode     = full_r;
    assign hwShutdown            = shut_r;
endmodule : asc_device

// File: hdl/asc_fifo.sv
// Result FIFO with valid/ready on both sides.
// Assumes one clock domain; storage is not reset.
`timescale 1ns/1ps
module asc_fifo
    import asc_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;

    assign inReady  = !((wrPtr_r[AW] != rdPtr_r[AW]) &&
                        (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]));
    assign outValid = (wrPtr_r != rdPtr_r);
    assign outData  = mem[rdPtr_r[AW-1:0]];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk)
    begin
        if (inValid && inReady)
            mem[wrPtr_r[AW-1:0]] <= inData;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wrPtr_r <= '0;
        else if (inValid && inReady)
            wrPtr_r <= wrPtr_r + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdPtr_r <= '0;
        else if (outValid && outReady)
            rdPtr_r <= rdPtr_r + 1'b1;
    end
endmodule : asc_fifo

// File: hdl/asc_host.sv
// Host end: Avalon-MM register slave that runs conversions over the link.
// Assumes the converter end on the same interface; results queue in a FIFO.
`timescale 1ns/1ps
module asc_host
    import asc_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Register bus
    input  wire logic [3:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [31:0] avsWriteData,
    input  wire logic [3:0]  avsByteEnable,
    output logic [31:0]      avsReadData,
    output logic             avsWaitrequest,
    // Serial link
    asc_link_if.host         link
);
    asc_host_state_type     state_r;
    logic [1:0]             sy1_r, sy2_r, sy3_r, st_r, stNxt;
    logic                   doutV, strobeFall;
    logic [4:0]             divCnt_r;
    logic                   sclk_r, tick, rise, fall, run;
    logic                   csN_r, din_r;
    logic [7:0]             txSh_r, ctrlByte_r;
    logic [4:0]             cnt_r;
    logic [RESULT_BITS-1:0] rxSh_r;
    logic                   push_r, startReq_r, timeout_r;
    logic                   waitReq_r;
    logic [31:0]            readData_r;
    logic                   req, done, ctrlWr, statWr, dataRd;
    logic                   fifoReady, fifoValid;
    logic [RESULT_BITS-1:0] fifoData;
    logic                   startNow, timeoutHit;

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for {result data, strobe}
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sy1_r <= HOST_SYNC_RESET;
            sy2_r <= HOST_SYNC_RESET;
            sy3_r <= HOST_SYNC_RESET;
            st_r  <= HOST_SYNC_RESET;
        end
        else
        begin
            sy1_r <= {link.doutLine, link.strobeLine};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            st_r  <= stNxt;
        end
    end

    always_comb
    begin
        for (int i = 0; i < 2; i++)
            stNxt[i] = ascFilt(sy2_r[i], sy3_r[i], st_r[i]);
    end

    assign doutV      = stNxt[1];
    assign strobeFall = st_r[0] & ~stNxt[0];

    ////////////////////////////////////////////////////////////////////////
    // Link clock divider: idle low, data changes on falling edges
    assign run  = (state_r != H_IDLE);
    assign tick = (divCnt_r == SCLK_HALF_LAST);
    assign rise = run && tick && !sclk_r;
    assign fall = run && tick && sclk_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_r <= 5'h00;
            sclk_r   <= 1'b0;
        end
        else if (!run)
        begin
            divCnt_r <= 5'h00;
            sclk_r   <= 1'b0;
        end
        else if (tick)
        begin
            divCnt_r <= 5'h00;
            // One rate serves every power mode and stays below the limit
            sclk_r   <= ~sclk_r;
        end
        else
            divCnt_r <= divCnt_r + 5'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    assign startNow   = (state_r == H_IDLE) && startReq_r && fifoReady;
    assign timeoutHit = (state_r == H_WAIT) && rise &&
                        (cnt_r == WAIT_LIMIT_CNT);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_r <= H_IDLE;
        else
            unique case (state_r)
                H_IDLE: if (startNow) state_r <= H_SEND;
                H_SEND: if (fall && cnt_r == CTRL_LAST_CNT) state_r <= H_WAIT;
                H_WAIT:
                    if (strobeFall)
                        state_r <= H_RECV;
                    else if (timeoutHit)
                        state_r <= H_DONE;
                H_RECV: if (rise && cnt_r == RX_LAST_CNT) state_r <= H_DONE;
                H_DONE: if (fall) state_r <= H_IDLE;
            endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            csN_r  <= 1'b1;
            din_r  <= 1'b0;
            txSh_r <= CTRL_RESET;
            cnt_r  <= 5'h00;
        end
        else if (startNow)
        begin
            csN_r  <= 1'b0;
            din_r  <= 1'b1;
            txSh_r <= {ctrlByte_r[6:0], 1'b0};
            cnt_r  <= 5'h00;
        end
        else if (state_r == H_SEND && fall)
        begin
            din_r  <= (cnt_r == CTRL_LAST_CNT) ? 1'b0 : txSh_r[7];
            txSh_r <= {txSh_r[6:0], 1'b0};
            cnt_r  <= (cnt_r == CTRL_LAST_CNT) ? 5'h00 : cnt_r + 5'h01;
        end
        else if (state_r == H_WAIT && strobeFall)
            cnt_r <= 5'h00;
        else if ((state_r == H_WAIT || state_r == H_RECV) && rise)
            cnt_r <= cnt_r + 5'h01;
        else if (state_r == H_DONE && fall)
            csN_r <= 1'b1;
    end

    // Only the first twelve captured bits are kept
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rxSh_r <= '0;
            push_r <= 1'b0;
        end
        else
        begin
            push_r <= 1'b0;
            if (startNow)
                rxSh_r <= '0;
            else if (state_r == H_RECV && rise)
            begin
                if (cnt_r < RESULT_BITS)
                    rxSh_r <= {rxSh_r[10:0], doutV};
                if (cnt_r == RX_LAST_CNT)
                    push_r <= 1'b1;
            end
        end
    end

    asc_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_DEPTH)
    ) asc_fifo_inst (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (push_r),
        .inReady  (fifoReady),
        .inData   (rxSh_r),
        .outValid (fifoValid),
        .outReady (dataRd),
        .outData  (fifoData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: waitrequest low one cycle after the request
    assign req    = avsRead || avsWrite;
    assign done   = req && !waitReq_r;
    assign ctrlWr = done && avsWrite && avsByteEnable[0] &&
                    avsAddress == REG_CTRL_OFS;
    assign statWr = done && avsWrite && avsByteEnable[0] &&
                    avsAddress == REG_STATUS_OFS;
    assign dataRd = done && avsRead && avsAddress == REG_DATA_OFS;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            waitReq_r <= 1'b1;
        else
            waitReq_r <= !(req && waitReq_r);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            readData_r <= 32'h0000_0000;
        else if (avsRead && waitReq_r)
        begin
            readData_r <= 32'h0000_0000;
            unique case (avsAddress)
                REG_CTRL_OFS:   readData_r[7:0] <= ctrlByte_r;
                REG_STATUS_OFS:
                begin
                    readData_r[ST_BUSY]    <= run || startReq_r;
                    readData_r[ST_NEMPTY]  <= fifoValid;
                    readData_r[ST_FULL]    <= !fifoReady;
                    readData_r[ST_TIMEOUT] <= timeout_r;
                end
                REG_DATA_OFS:
                begin
                    readData_r[DATA_VALID_POS]  <= fifoValid;
                    readData_r[RESULT_BITS-1:0] <= fifoData;
                end
                default:        readData_r <= 32'h0000_0000;
            endcase
        end
    end

    // Control writes while a transfer is pending or running are ignored
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrlByte_r <= CTRL_RESET;
            startReq_r <= 1'b0;
        end
        else if (ctrlWr && !run && !startReq_r)
        begin
            ctrlByte_r <= avsWriteData[7:0];
            startReq_r <= 1'b1;
        end
        else if (startNow)
            startReq_r <= 1'b0;
    end

    // Set wins over a simultaneous software clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            timeout_r <= 1'b0;
        else if (timeoutHit)
            timeout_r <= 1'b1;
        else if (statWr && avsWriteData[ST_TIMEOUT])
            timeout_r <= 1'b0;
    end

    assign link.csN       = csN_r;
    assign link.sclk      = sclk_r;
    assign link.din       = din_r;
    assign avsReadData    = readData_r;
    assign avsWaitrequest = waitReq_r;
endmodule : asc_host

// File: hdl/asc_link_if.sv
// Five-wire serial link between converter end and host end.
// Released outputs read low on the wire.
`timescale 1ns/1ps
interface asc_link_if;
    logic csN;
    logic sclk;
    logic din;
    logic dout;
    logic doutOe;
    logic conversionStrobe;
    logic strobeOe;
    logic doutLine;
    logic strobeLine;

    assign doutLine   = doutOe & dout;
    assign strobeLine = strobeOe & conversionStrobe;

    modport dev  (input csN, sclk, din,
                  output dout, doutOe, conversionStrobe, strobeOe);
    modport host (output csN, sclk, din, input doutLine, strobeLine);
endinterface : asc_link_if

// File: hdl/asc_pkg.sv
// Shared constants, types and helpers of the serial conversion sequencer.
// Assumes a 200 MHz system clock shared by both ends.
package asc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clocking
    localparam int MCLK_FREQ_KHZ   = 200000;
    localparam int SCLK_FREQ_KHZ   = 4000;
    localparam int SCLK_LP_MAX_KHZ = 4800;
    // Least half period, rounded up, so the link never runs fast
    localparam int SCLK_HALF_CYC   =
        (MCLK_FREQ_KHZ + 2 * SCLK_FREQ_KHZ - 1) / (2 * SCLK_FREQ_KHZ);
    localparam logic [4:0] SCLK_HALF_LAST = 5'(SCLK_HALF_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // Control byte and frame layout
    localparam int CTRL_BITS   = 8;
    localparam int RESULT_BITS = 12;
    localparam int FRAME_BITS  = 16;
    localparam int CB_START    = 7;
    localparam int CB_CFG_LSB  = 2;
    localparam int CB_CFG_W    = 5;
    localparam int CB_PD_LSB   = 0;
    localparam logic [4:0] CTRL_LAST_CNT  = 5'(CTRL_BITS - 1);
    localparam logic [4:0] FRAME_LAST_CNT = 5'(FRAME_BITS);
    localparam logic [4:0] RX_LAST_CNT    = 5'(FRAME_BITS - 1);
    localparam logic [4:0] WAIT_LIMIT_CNT = 5'h1F;

    ////////////////////////////////////////////////////////////////////////
    // Power-mode codes
    localparam logic [1:0] PD_FULL    = 2'h0;
    localparam logic [1:0] PD_FAST    = 2'h1;
    localparam logic [1:0] PD_REDUCED = 2'h2;
    localparam logic [1:0] PD_NORMAL  = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Host register map and reset values
    localparam logic [3:0]  REG_CTRL_OFS   = 4'h0;
    localparam logic [3:0]  REG_STATUS_OFS = 4'h4;
    localparam logic [3:0]  REG_DATA_OFS   = 4'h8;
    localparam int          ST_BUSY        = 0;
    localparam int          ST_NEMPTY      = 1;
    localparam int          ST_FULL        = 2;
    localparam int          ST_TIMEOUT     = 3;
    localparam int          DATA_VALID_POS = 31;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [1:0]  MODE_RESET     = PD_NORMAL;
    localparam logic [3:0]  DEV_SYNC_RESET = 4'hC;
    localparam logic [1:0]  HOST_SYNC_RESET = 2'h0;
    localparam int          FIFO_WIDTH     = 12;
    localparam int          FIFO_DEPTH     = 8;

    ////////////////////////////////////////////////////////////////////////
    // State types
    typedef enum logic [4:0] {
        D_IDLE = 5'h01, D_CTRL = 5'h02, D_ARM = 5'h04,
        D_STRB = 5'h08, D_DATA = 5'h10
    } asc_dev_state_type;

    typedef enum logic [4:0] {
        H_IDLE = 5'h01, H_SEND = 5'h02, H_WAIT = 5'h04,
        H_RECV = 5'h08, H_DONE = 5'h10
    } asc_host_state_type;

    // New stable level once the last two synchroniser stages agree
    function automatic logic ascFilt(input logic s2, input logic s3,
                                     input logic st);
        return (s2 == s3) ? s3 : st;
    endfunction : ascFilt

endpackage : asc_pkg

// File: tb/adc_serial_conversion_sequencer_tb.sv
// Bench: host and converter ends joined over the link, run over Avalon-MM.
// Assumes both ends share mclk; results return through the host FIFO.
`timescale 1ns/1ps
module adc_serial_conversion_sequencer_tb
    import asc_pkg::*;
;
    logic        mclk, rst, hwShutdownN, avsRead, avsWrite, avsWaitrequest;
    logic        sampleTaken, conversionBusy, normalMode, fastPowerdownMode;
    logic        reducedPowerMode, fullPowerdownMode, hwShutdown;
    logic [3:0]  avsAddress;
    logic [31:0] avsWriteData, avsReadData, q;
    logic [11:0] sampleData, s;
    logic [4:0]  channelConfig;
    logic [7:0]  ctrl;
    logic [11:0] expQ[$];
    int          bad_count, checked, takenCnt;
    asc_link_if link();
    asc_device asc_device_inst(.mclk, .rst, .link(link), .hwShutdownN,
        .sampleData, .sampleTaken, .channelConfig, .conversionBusy,
        .normalMode, .fastPowerdownMode, .reducedPowerMode,
        .fullPowerdownMode, .hwShutdown);
    asc_host asc_host_inst(.mclk, .rst, .avsAddress, .avsRead, .avsWrite,
        .avsWriteData, .avsByteEnable(4'hF), .avsReadData, .avsWaitrequest,
        .link(link));
    asc_link_assertions asc_link_assertions_inst(.mclk, .rst,
        .csN(link.csN), .sclk(link.sclk), .din(link.din),
        .doutLine(link.doutLine), .strobeLine(link.strobeLine));
    ////////////////////////////////////////////////////////////////////////
    always #2.5 mclk = ~mclk;
    always @(posedge mclk)
        if (sampleTaken === 1'b1)
            takenCnt++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a);
        avsAddress   <= a;
        avsWriteData <= {24'h0, ctrl};
        avsWrite     <= wr;
        avsRead      <= !wr;
        do
            @(posedge mclk);
        while (avsWaitrequest !== 1'b0);
        q = avsReadData;
        avsWrite <= 1'b0;
        avsRead  <= 1'b0;
        @(posedge mclk);
    endtask : bus
    function automatic logic [3:0] modeOf(input logic [1:0] pd);
        case (pd)
            PD_NORMAL:  return 4'h1;
            PD_FAST:    return 4'h2;
            PD_REDUCED: return 4'h4;
            default:    return 4'h8;
        endcase
    endfunction : modeOf
    task automatic stop_test;
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300000;
        bad_count++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'h1791));
        {mclk, avsRead, avsWrite, avsAddress, sampleData, ctrl} = '0;
        rst = 1'b1;
        hwShutdownN = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            ctrl = {1'b1, 5'($urandom), 2'(i)};
            s = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
            sampleData <= s;
            expQ.push_back(s);
            bus(1'b1, REG_CTRL_OFS);
            wait (conversionBusy === 1'b1);
            #1 chk(32'(normalMode), 32'h1);
            @(posedge mclk);
            do
                bus(1'b0, REG_STATUS_OFS);
            while (q[ST_BUSY] !== 1'b0);
            repeat (10) @(posedge mclk);
            chk(32'({fullPowerdownMode, reducedPowerMode, fastPowerdownMode,
                normalMode}), 32'(modeOf(ctrl[1:0])));
            chk(32'(channelConfig), 32'(ctrl[6:2]));
        end
        chk(32'(takenCnt), 32'(FIFO_DEPTH));
        bus(1'b0, REG_STATUS_OFS);
        chk(32'(q[3:0]), 32'h6);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            bus(1'b0, REG_DATA_OFS);
            chk(32'({q[31], q[11:0]}), 32'({1'b1, expQ.pop_front()}));
        end
        bus(1'b0, REG_DATA_OFS);
        chk(32'(q[31]), 32'h0);
        bus(1'b0, 4'hC);
        chk(q, 32'h0);
        hwShutdownN <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(32'({hwShutdown, fullPowerdownMode, reducedPowerMode,
            fastPowerdownMode, normalMode}), 32'h10);
        hwShutdownN <= 1'b1;
        stop_test();
    end
endmodule : adc_serial_conversion_sequencer_tb

// File: tb/asc_link_assertions.sv
// Checker on the serial wires between the converter end and the host end.
// Assumes a 200 MHz mclk and a link clock made by the host end.
`timescale 1ns/1ps
module asc_link_assertions
    import asc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Link wires
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    input wire logic doutLine,
    input wire logic strobeLine
);
    logic [5:0] riseCnt_r;
    logic [5:0] phaseCnt_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Link clock rises since the strobe fell, saturating
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            riseCnt_r <= 6'h3F;
        else if ($fell(strobeLine))
            riseCnt_r <= 6'h00;
        else if ($rose(sclk) && riseCnt_r != 6'h3F)
            riseCnt_r <= riseCnt_r + 6'h01;
    // Mclk cycles since the link clock last changed, saturating
    always_ff @(posedge mclk or posedge rst)
        if (rst)
            phaseCnt_r <= 6'h00;
        else if ($changed(sclk))
            phaseCnt_r <= 6'h00;
        else if (phaseCnt_r != 6'h3F)
            phaseCnt_r <= phaseCnt_r + 6'h01;
    sequence strobePulse;
        strobeLine [*8] ##[1:60] !strobeLine;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_idle_clock_low: assert property (csN [*2] |-> !sclk)
        else $error("link clock runs while deselected");
    a_clock_half_high: assert property ($rose(sclk) |=> sclk [*8])
        else $error("link clock high phase too short");
    a_clock_rate: assert property ($fell(sclk) |->
        phaseCnt_r == 6'(SCLK_HALF_CYC - 1))
        else $error("link clock high phase not one half period");
    a_released_quiet: assert property (csN [*8] |-> !strobeLine && !doutLine)
        else $error("outputs not released while deselected");
    a_strobe_one_period: assert property ($rose(strobeLine) |=> strobePulse)
        else $error("strobe pulse width wrong");
    a_strobe_sclk_low: assert property ($rose(strobeLine) |-> !sclk)
        else $error("strobe rose outside clock low phase");
    a_trailing_zero: assert property ($rose(sclk) && riseCnt_r inside {[12:15]}
        |-> !doutLine)
        else $error("trailing frame bit not zero");
    a_frame_end: assert property ($rose(csN) |-> riseCnt_r == 6'h10)
        else $error("select rose without sixteen captures");
    a_start_bit_first: assert property ($fell(csN) |=> din [*8])
        else $error("first bit after select is not high");
endmodule : asc_link_assertions
